// >>> rtl/pfm_pin_function_mux.sv
`timescale 1ns/1ns
module pfm_pin_function_mux #(
   parameter int unsigned STRETCH = pfm_pkg::RESET_STRETCH_CYCLES
)(
   input  wire logic                            clock_i,
   input  wire logic                            sys_rst_i,
   // Pad signals
   input  wire logic [pfm_pkg::PIN_COUNT-1:0]   pad_in_i,
   output logic      [pfm_pkg::PIN_COUNT-1:0]   pad_out_o,
   output logic      [pfm_pkg::PIN_COUNT-1:0]   pad_oe_o,
   // Software controls
   input  wire logic                            cfg_we_i,
   input  wire logic [pfm_pkg::PIN_COUNT-1:0]   periph_en_i,
   input  wire logic [2*pfm_pkg::PIN_COUNT-1:0] periph_sel_i,
   input  wire logic [pfm_pkg::PIN_COUNT-1:0]   gpio_dir_i,
   input  wire logic [pfm_pkg::PIN_COUNT-1:0]   gpio_data_i,
   input  wire logic [pfm_pkg::CLKSEL_W-1:0]    clock_out_source_select_i,
   // Other reset sources
   input  wire logic                            power_on_rst_i,
   input  wire logic                            watchdog_timeout_i,
   input  wire logic                            soft_rst_i,
   // Peripheral side
   input  wire logic                            serial0_transmit_i,
   input  wire logic                            serial0_transmit_oe_i,
   output logic                                 serial0_receive_o,
   input  wire logic                            crossbar_output_eleven_i,
   output logic                                 crossbar_input_two_o,
   input  wire logic [pfm_pkg::CLK_SRC_COUNT-1:0] clock_sources_i,
   output logic                                 test_clock_o,
   output logic                                 crystal_in_o,
   output logic                                 ext_clock_in_zero_o,
   input  wire logic                            crystal_out_i,
   // Status
   output logic [pfm_pkg::PIN_COUNT-1:0]        gpio_in_o,
   output logic [pfm_pkg::PIN_COUNT-1:0]        periph_en_o,
   output logic [pfm_pkg::PIN_COUNT-1:0]        gpio_dir_o,
   output logic                                 pin_reset_enabled_o,
   output logic                                 internal_rst_o
);

   localparam int unsigned N = pfm_pkg::PIN_COUNT;

   // ------------------------------------------------------------
   // Helper
   // ------------------------------------------------------------
   function automatic logic [1:0] pfm_sel_of(input logic [2*N-1:0] v, input int unsigned p);
      pfm_sel_of = v[2*p +: 2];
   endfunction

   // ------------------------------------------------------------
   // Pad input synchronisers
   // ------------------------------------------------------------
   logic [N-1:0] pad_sync;

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_sync
         pfm_sync3 #(
            .RST_VAL (1'b1)
         ) u_sync (
            .clock_i   (clock_i),
            .sys_rst_i (sys_rst_i),
            .async_i   (pad_in_i[g]),
            .sync_o    (pad_sync[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [N-1:0]                   periph_en_r;
   logic [2*N-1:0]                 periph_sel_r;
   logic [N-1:0]                   dir_r;
   logic [N-1:0]                   data_r;
   logic [pfm_pkg::CLKSEL_W-1:0]   clksel_r;
   logic                           internal_rst_r;

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i || internal_rst_r)
      begin
         periph_en_r  <= pfm_pkg::PERIPH_EN_RST;
         periph_sel_r <= pfm_pkg::PERIPH_SEL_RST;
         dir_r        <= pfm_pkg::DIR_RST;
         data_r       <= pfm_pkg::DATA_RST;
         clksel_r     <= pfm_pkg::CLKSEL_RST;
      end
      else if (cfg_we_i)
      begin
         periph_en_r  <= periph_en_i;
         periph_sel_r <= periph_sel_i;
         dir_r        <= gpio_dir_i;
         data_r       <= gpio_data_i;
         clksel_r     <= clock_out_source_select_i;
      end
   end

   // ------------------------------------------------------------
   // Reset pin and release stretch
   // ------------------------------------------------------------
   logic                         pin_rst_en;
   logic                         rst_req;
   logic [pfm_pkg::STRETCH_W-1:0] stretch_r;

   assign pin_rst_en = periph_en_r[pfm_pkg::PIN_RESET];
   assign rst_req    = (pin_rst_en && !pad_sync[pfm_pkg::PIN_RESET])
                       || power_on_rst_i || watchdog_timeout_i || soft_rst_i;

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i || rst_req)
         stretch_r <= '0;
      else if (stretch_r != pfm_pkg::STRETCH_W'(STRETCH))
         stretch_r <= stretch_r + pfm_pkg::STRETCH_W'(1);
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i || rst_req)
         internal_rst_r <= 1'b1;
      else
         internal_rst_r <= (stretch_r != pfm_pkg::STRETCH_W'(STRETCH));
   end

   // ------------------------------------------------------------
   // Clock output source selection
   // ------------------------------------------------------------
   logic clock_out_zero;
   assign clock_out_zero = clock_sources_i[clksel_r];

   // ------------------------------------------------------------
   // Pin output muxing
   // ------------------------------------------------------------
   logic [N-1:0] per_out;
   logic [N-1:0] per_oe;

   always_comb
   begin
      per_out = '0;
      per_oe  = '0;
      // Pins 1 to 3 primary functions are inputs only
      per_out[pfm_pkg::PIN_CRYSTAL_OUT] = crystal_out_i;
      per_oe[pfm_pkg::PIN_CRYSTAL_OUT]  = 1'b1;
      case (pfm_sel_of(periph_sel_r, pfm_pkg::PIN_SERIAL))
         pfm_pkg::SEL_SERIAL0_TRANSMIT:
         begin
            per_out[pfm_pkg::PIN_SERIAL] = serial0_transmit_i;
            per_oe[pfm_pkg::PIN_SERIAL]  = serial0_transmit_oe_i;
         end
         pfm_pkg::SEL_XBAR_OUT_ELEVEN:
         begin
            per_out[pfm_pkg::PIN_SERIAL] = crossbar_output_eleven_i;
            per_oe[pfm_pkg::PIN_SERIAL]  = 1'b1;
         end
         pfm_pkg::SEL_CLOCK_OUT_ZERO:
         begin
            per_out[pfm_pkg::PIN_SERIAL] = clock_out_zero;
            per_oe[pfm_pkg::PIN_SERIAL]  = 1'b1;
         end
         default:
         begin
            per_out[pfm_pkg::PIN_SERIAL] = 1'b0;
            per_oe[pfm_pkg::PIN_SERIAL]  = 1'b0;
         end
      endcase
   end

   generate
      for (g = 0; g < N; g++)
      begin : g_pad
         always_ff @(posedge clock_i)
         begin
            if (sys_rst_i || internal_rst_r)
            begin
               pad_out_o[g] <= 1'b0;
               pad_oe_o[g]  <= 1'b0;
            end
            else if (periph_en_r[g])
            begin
               pad_out_o[g] <= per_out[g];
               pad_oe_o[g]  <= per_oe[g];
            end
            else
            begin
               pad_out_o[g] <= data_r[g];
               pad_oe_o[g]  <= dir_r[g];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Pin input routing
   // ------------------------------------------------------------
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         test_clock_o         <= 1'b1;
         crystal_in_o         <= 1'b0;
         ext_clock_in_zero_o  <= 1'b0;
         serial0_receive_o    <= 1'b1;
         crossbar_input_two_o <= 1'b0;
         gpio_in_o            <= '0;
      end
      else
      begin
         test_clock_o <= periph_en_r[pfm_pkg::PIN_TEST_CLK]
                         ? pad_sync[pfm_pkg::PIN_TEST_CLK] : 1'b1;
         crystal_in_o <= periph_en_r[pfm_pkg::PIN_CRYSTAL_IN]
                         && pfm_sel_of(periph_sel_r, pfm_pkg::PIN_CRYSTAL_IN)
                            == pfm_pkg::SEL_CRYSTAL_IN
                         && pad_sync[pfm_pkg::PIN_CRYSTAL_IN];
         ext_clock_in_zero_o <= periph_en_r[pfm_pkg::PIN_CRYSTAL_IN]
                         && pfm_sel_of(periph_sel_r, pfm_pkg::PIN_CRYSTAL_IN)
                            == pfm_pkg::SEL_EXT_CLOCK_IN
                         && pad_sync[pfm_pkg::PIN_CRYSTAL_IN];
         serial0_receive_o <= (periph_en_r[pfm_pkg::PIN_SERIAL]
                         && pfm_sel_of(periph_sel_r, pfm_pkg::PIN_SERIAL)
                            == pfm_pkg::SEL_SERIAL0_TRANSMIT)
                         ? pad_sync[pfm_pkg::PIN_SERIAL] : 1'b1;
         crossbar_input_two_o <= periph_en_r[pfm_pkg::PIN_SERIAL]
                         && pfm_sel_of(periph_sel_r, pfm_pkg::PIN_SERIAL)
                            == pfm_pkg::SEL_XBAR_IN_TWO
                         && pad_sync[pfm_pkg::PIN_SERIAL];
         gpio_in_o <= pad_sync & ~periph_en_r;
      end
   end

   assign periph_en_o         = periph_en_r;
   assign gpio_dir_o          = dir_r;
   assign pin_reset_enabled_o = pin_rst_en;
   assign internal_rst_o      = internal_rst_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_pin_reset_low;
      pin_rst_en && !pad_sync[pfm_pkg::PIN_RESET];
   endsequence

   AST_DEFAULT_PRIMARY: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      internal_rst_r |=> periph_en_r == pfm_pkg::PERIPH_EN_RST
                         && periph_sel_r == pfm_pkg::PERIPH_SEL_RST)
      else $error("pin functions not at primary after reset");

   AST_CFG_LOAD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      cfg_we_i && !internal_rst_r && !rst_req |=> periph_en_r == $past(periph_en_i))
      else $error("peripheral enable not loaded");

   AST_GPIO_DIR: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !internal_rst_r && !periph_en_r[pfm_pkg::PIN_CRYSTAL_IN]
      |=> pad_oe_o[pfm_pkg::PIN_CRYSTAL_IN] == $past(dir_r[pfm_pkg::PIN_CRYSTAL_IN]))
      else $error("general-purpose direction not applied");

   AST_TEST_CLOCK: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      periph_en_r[pfm_pkg::PIN_TEST_CLK] |=> test_clock_o == $past(pad_sync[pfm_pkg::PIN_TEST_CLK]))
      else $error("test clock not routed");

   AST_RESET_HOLD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      s_pin_reset_low |=> internal_rst_r [*2])
      else $error("reset pin low did not hold reset");

   AST_RELEASE_DELAY: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      $fell(rst_req) |-> internal_rst_r [*8])
      else $error("internal reset released too early");

   AST_PIN_RESET_OFF: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !internal_rst_r && !pin_rst_en && !power_on_rst_i && !watchdog_timeout_i
      && !soft_rst_i |=> !internal_rst_r)
      else $error("reset pin acted while disabled");

   AST_PERIPH_DRIVE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !internal_rst_r && periph_en_r[pfm_pkg::PIN_CRYSTAL_OUT]
      |=> pad_out_o[pfm_pkg::PIN_CRYSTAL_OUT] == $past(crystal_out_i)
          && pad_oe_o[pfm_pkg::PIN_CRYSTAL_OUT])
      else $error("crystal out not driven by peripheral");

endmodule

// >>> include/pfm_pkg.sv
package pfm_pkg;

   // ------------------------------------------------------------
   // Pin count and selector widths
   // ------------------------------------------------------------
   localparam int unsigned PIN_COUNT      = 5;
   localparam int unsigned SEL_W          = 2;
   localparam int unsigned CLKSEL_W       = 3;
   localparam int unsigned CLK_SRC_COUNT  = 8;

   // ------------------------------------------------------------
   // Pin indices
   // ------------------------------------------------------------
   localparam int unsigned PIN_TEST_CLK   = 0;
   localparam int unsigned PIN_RESET      = 1;
   localparam int unsigned PIN_CRYSTAL_IN = 2;
   localparam int unsigned PIN_CRYSTAL_OUT = 3;
   localparam int unsigned PIN_SERIAL     = 4;

   // ------------------------------------------------------------
   // Peripheral select codes on the serial pin
   // ------------------------------------------------------------
   localparam logic [1:0] SEL_SERIAL0_TRANSMIT = 2'h0;
   localparam logic [1:0] SEL_XBAR_OUT_ELEVEN  = 2'h1;
   localparam logic [1:0] SEL_XBAR_IN_TWO      = 2'h2;
   localparam logic [1:0] SEL_CLOCK_OUT_ZERO   = 2'h3;

   // Crystal input pin: select 0 oscillator input, select 1 external clock in
   localparam logic [1:0] SEL_CRYSTAL_IN       = 2'h0;
   localparam logic [1:0] SEL_EXT_CLOCK_IN     = 2'h1;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [4:0] PERIPH_EN_RST   = 5'h03;
   localparam logic [4:0] DIR_RST         = 5'h00;
   localparam logic [4:0] DATA_RST        = 5'h00;
   localparam logic [9:0] PERIPH_SEL_RST  = 10'h000;
   localparam logic [2:0] CLKSEL_RST      = 3'h0;

   // ------------------------------------------------------------
   // Reset release timing
   // ------------------------------------------------------------
   localparam int unsigned RESET_STRETCH_CYCLES = 32;
   localparam int unsigned STRETCH_W            = 6;

endpackage

// >>> rtl/pfm_sync3.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Three-stage synchroniser; output changes when stages 2 and 3 agree
// ------------------------------------------------------------
module pfm_sync3 #(
   parameter logic RST_VAL = 1'b0
)(
   input  wire logic clock_i,
   input  wire logic sys_rst_i,
   input  wire logic async_i,
   output logic      sync_o
);

   logic meta_r;
   logic stage2_r;
   logic stage3_r;

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         meta_r   <= RST_VAL;
         stage2_r <= RST_VAL;
         stage3_r <= RST_VAL;
      end
      else
      begin
         meta_r   <= async_i;
         stage2_r <= meta_r;
         stage3_r <= stage2_r;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         sync_o <= RST_VAL;
      else if (stage2_r == stage3_r)
         sync_o <= stage3_r;
   end

endmodule

// >>> verif/pfm_board_model.sv
`timescale 1ns/1ns
module pfm_board_model (
   input  wire logic [pfm_pkg::PIN_COUNT-1:0] pad_out_i,
   input  wire logic [pfm_pkg::PIN_COUNT-1:0] pad_oe_i,
   input  wire logic [pfm_pkg::PIN_COUNT-1:0] board_i,
   output logic      [pfm_pkg::PIN_COUNT-1:0] pad_level_o
);
   // ------------------------------------------------------------
   // Pads driven by the device win; the board drives the rest
   // ------------------------------------------------------------
   assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & board_i);
endmodule

// >>> verif/tb_pin_function_mux.sv
`timescale 1ns/1ns
module tb_pin_function_mux;
   localparam int ST = 8;
   logic       clock_i = 1'b0;
   logic       rst = 1'b1;
   logic       we = 1'b0;
   logic       tx = 1'b0, txoe = 1'b0, xb = 1'b0, xo = 1'b0, pin_lv = 1'b1;
   logic [2:0] rs = 3'h0, cks = 3'h0;
   logic [4:0] en = 5'h03, dir = 5'h00, dat = 5'h00, brd = 5'h1f;
   logic [4:0] lvl, po, poe, gin, peno, gdo;
   logic [7:0] src = 8'h00;
   logic [9:0] sel = 10'h000;
   logic       rxo, xbi, tco, cio, eco, pre, irst;
   int         miscompares = 0, n_tests = 0, n;
   logic [31:0] r;

   pfm_board_model pfm_board_model_inst (.pad_out_i(po), .pad_oe_i(poe), .board_i(brd),
      .pad_level_o(lvl));
   pfm_pin_function_mux #(.STRETCH(ST)) pfm_pin_function_mux_inst (.clock_i(clock_i),
      .sys_rst_i(rst), .pad_in_i(lvl), .pad_out_o(po), .pad_oe_o(poe), .cfg_we_i(we),
      .periph_en_i(en), .periph_sel_i(sel), .gpio_dir_i(dir), .gpio_data_i(dat),
      .clock_out_source_select_i(cks), .power_on_rst_i(rs[0]), .watchdog_timeout_i(rs[1]),
      .soft_rst_i(rs[2]), .serial0_transmit_i(tx), .serial0_transmit_oe_i(txoe),
      .serial0_receive_o(rxo), .crossbar_output_eleven_i(xb), .crossbar_input_two_o(xbi),
      .clock_sources_i(src), .test_clock_o(tco), .crystal_in_o(cio),
      .ext_clock_in_zero_o(eco), .crystal_out_i(xo), .gpio_in_o(gin), .periph_en_o(peno),
      .gpio_dir_o(gdo), .pin_reset_enabled_o(pre), .internal_rst_o(irst));

   initial
   begin
      forever #20 clock_i = ~clock_i;
   end

   // ------------------------------------------------------------
   // Reference model and shared tasks
   // ------------------------------------------------------------
   function automatic logic [9:0] model();
      logic [4:0] oe;
      logic [4:0] o;
      oe = dir & ~en;
      o = dat & oe;
      if (en[3])
      begin
         oe[3] = 1'b1;
         o[3] = xo;
      end
      if (en[4])
      begin
         case (sel[9:8])
            pfm_pkg::SEL_SERIAL0_TRANSMIT: {oe[4], o[4]} = {txoe, tx & txoe};
            pfm_pkg::SEL_XBAR_OUT_ELEVEN:  {oe[4], o[4]} = {1'b1, xb};
            pfm_pkg::SEL_XBAR_IN_TWO:      {oe[4], o[4]} = 2'b00;
            default:                       {oe[4], o[4]} = {1'b1, src[cks]};
         endcase
      end
      return {oe, o};
   endfunction

   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_all();
      logic [9:0] m;
      logic [4:0] w;
      m = model();
      w = (m[9:5] & m[4:0]) | (~m[9:5] & brd);
      chk(poe, m[9:5]);
      chk(po & m[9:5], m[4:0]);
      chk(lvl, w);
      chk(gin, w & ~en);
      chk({gdo, peno}, {dir, en});
      chk(pre, en[1]);
      chk(tco, en[0] ? w[0] : 1'b1);
      chk({eco, cio}, {2{en[2] && w[2]}} & {sel[5:4] == 2'h1, sel[5:4] == 2'h0});
      chk(rxo, en[4] && sel[9:8] == 2'h0 ? w[4] : 1'b1);
      chk(xbi, en[4] && sel[9:8] == 2'h2 && w[4]);
   endtask

   task automatic cfg(input logic [4:0] e, input logic [9:0] s, input logic [4:0] d,
                      input logic [4:0] v, input logic [2:0] c);
      @(posedge clock_i);
      r = $urandom;
      en <= e;
      sel <= s;
      dir <= d;
      dat <= v;
      cks <= c;
      {tx, txoe, xb, xo} <= r[3:0];
      src <= r[11:4];
      brd <= (r[16:12] & 5'h1d) | {3'h0, pin_lv, 1'b0};
      we <= 1'b1;
      @(posedge clock_i);
      we <= 1'b0;
      repeat (8) @(posedge clock_i);
      #1;
   endtask

   task automatic wait_rst(input logic lv);
      n = 0;
      while (irst !== lv && n < 60)
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
   endtask

   task automatic expect_reset();
      @(posedge clock_i);
      en <= pfm_pkg::PERIPH_EN_RST;
      sel <= pfm_pkg::PERIPH_SEL_RST;
      dir <= pfm_pkg::DIR_RST;
      dat <= pfm_pkg::DATA_RST;
      cks <= pfm_pkg::CLKSEL_RST;
      #1;
      check_all();
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h63fd));
      repeat (16) @(posedge clock_i);
      rst <= 1'b0;
      repeat (20) @(posedge clock_i);
      #1;
      check_all();
      chk(irst, 1'b0);
      $display("test defaults done");
      // Every pin-5 select first, clock out on sources 3 and 7 only, then random mixes
      for (int i = 0; i < 40; i++)
      begin
         r = $urandom;
         cfg(i < 8 ? (r[4:0] | 5'h10) : r[4:0], {i < 8 ? 2'(i) : r[9:8], r[7:6], 1'b0,
             r[14:10]}, r[19:15], r[24:20] | 5'h02, i < 8 ? 3'(i) : r[27:25]);
         check_all();
      end
      $display("test mux done");
      pin_lv = 1'b0;
      cfg(5'h03, 10'h000, 5'h00, 5'h00, 3'h0);
      chk(irst, 1'b1);
      cfg(5'h00, 10'h000, 5'h1f, 5'h1f, 3'h0);
      chk({irst, peno}, {1'b1, pfm_pkg::PERIPH_EN_RST});
      pin_lv = 1'b1;
      @(posedge clock_i);
      brd[1] <= 1'b1;
      wait_rst(1'b0);
      chk(n >= ST && n <= ST + 10, 1'b1);
      expect_reset();
      $display("test reset pin done");
      cfg(5'h00, 10'h000, 5'h00, 5'h00, 3'h0);
      pin_lv = 1'b0;
      cfg(5'h00, 10'h000, 5'h00, 5'h00, 3'h0);
      chk({irst, pre}, 2'b00);
      check_all();
      pin_lv = 1'b1;
      $display("test reset pin off done");
      for (int k = 0; k < 3; k++)
      begin
         cfg(5'h1d, 10'h300, 5'h1f, 5'h0a, 3'h5);
         @(posedge clock_i);
         rs <= 3'h1 << k;
         @(posedge clock_i);
         rs <= 3'h0;
         #1;
         chk(irst, 1'b1);
         @(posedge clock_i);
         #1;
         chk(poe, 5'h00);
         wait_rst(1'b0);
         chk(n >= ST - 1 && n <= ST + 3, 1'b1);
         expect_reset();
      end
      $display("test reset sources done");
      give_verdict();
   end

   initial
   begin
      #(40 * 20000);
      miscompares++;
      give_verdict();
   end
endmodule
